// >>> shared/rbx_pkg.sv
// Opcodes, states, constants and reset values for the execution block
`default_nettype none
package rbx_pkg;
  // ==========================================================
  // Operations and states
  typedef enum logic [5:0] {
    OP_NONE, OP_BR_LEZ, OP_BR_LEZ_LK, OP_BR_LTZ, OP_BR_LTZ_LK,
    OP_BR_LTZ_LNK, OP_BR_LTZ_LNK_LK, OP_BR_NE, OP_BR_NE_LK,
    OP_DEBUG_RET, OP_EXC_RET, OP_QUOT_S, OP_QUOT_U, OP_BARRIER,
    OP_FIELD_PULL, OP_FIELD_PUT, OP_JUMP_LINK, OP_JUMP_LINK_HB,
    OP_JUMP_HB, OP_CJUMP, OP_CJUMP_LINK, OP_LOAD_LINKED, OP_UPPER_IMM,
    OP_LOAD_PCREL, OP_LOAD_WORD, OP_LOAD_BYTE, OP_LOAD_BYTE_U,
    OP_LOAD_HALF, OP_LOAD_HALF_U, OP_ACC_S, OP_ACC_U, OP_DED_S,
    OP_DED_U, OP_CP0_READ, OP_CP0_WRITE, OP_MOVE_ZERO, OP_MOVE_NONZERO,
    OP_PROD_REG, OP_PROD_S, OP_PROD_U, OP_READ_TOP, OP_READ_BOTTOM
  } rbx_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOAD = 2'h1,
    ST_BARRIER = 2'h2
  } rbx_state_t;
  // ==========================================================
  // Constants
  localparam int SIGN_BIT = 31;
  localparam int OFFSET_SHIFT = 2;
  localparam int UPPER_SHIFT = 16;
  localparam int STATUS_ERL_BIT = 2;
  localparam int STATUS_EXL_BIT = 1;
  localparam logic [4:0] LINK_REG = 5'h1F;
  localparam logic [31:0] LINK_STEP = 32'h0000_0008;
  localparam logic [31:0] COMPACT_STEP = 32'h0000_0002;
  localparam logic [4:0] CP0_STATUS = 5'h0C;
  localparam logic [4:0] CP0_EXC_PC = 5'h0E;
  localparam logic [4:0] CP0_DEBUG_PC = 5'h18;
  localparam logic [4:0] CP0_ERROR_PC = 5'h1E;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [63:0] PAIR_RESET = 64'h0000_0000_0000_0000;
endpackage
`default_nettype wire

// >>> rtl/rbx_bit_field.sv
// Bit-field pull and put unit
`default_nettype none
module rbx_bit_field #(
  parameter int WIDTH = 32
) (
  // Operands
  input wire logic [WIDTH-1:0] srcWord,
  input wire logic [WIDTH-1:0] tgtWord,
  input wire logic [$clog2(WIDTH)-1:0] pos,
  input wire logic [$clog2(WIDTH):0] size,
  // Results
  output logic [WIDTH-1:0] pulled,
  output logic [WIDTH-1:0] put
);
  if (WIDTH < 2 || (WIDTH & (WIDTH - 1)) != 0) begin : gChk
    $error("rbx_bit_field WIDTH must be a power of two");
  end
  // Extra top bit lets a full-width size yield an all-ones mask
  wire [WIDTH:0] maskWide = ({{WIDTH{1'b0}}, 1'b1} << size) - 1'b1;
  wire [WIDTH-1:0] fieldMask = maskWide[WIDTH-1:0];
  assign pulled = (srcWord >> pos) & fieldMask;
  assign put = (tgtWord & ~(fieldMask << pos)) | ((srcWord & fieldMask) << pos);
endmodule
`default_nettype wire

// >>> rtl/rbx_product_unit.sv
// Multiply and divide arithmetic for the top/bottom pair
`default_nettype none
module rbx_product_unit #(
  parameter int WIDTH = 32
) (
  // Operands
  input wire logic [WIDTH-1:0] opA,
  input wire logic [WIDTH-1:0] opB,
  // Products
  output logic [2*WIDTH-1:0] prodS,
  output logic [2*WIDTH-1:0] prodU,
  // Quotients and remainders
  output logic [WIDTH-1:0] quoS,
  output logic [WIDTH-1:0] remS,
  output logic [WIDTH-1:0] quoU,
  output logic [WIDTH-1:0] remU
);
  if (WIDTH < 2) begin : gChk
    $error("rbx_product_unit WIDTH too small");
  end
  wire divZero = (opB == '0);
  wire signed [2*WIDTH-1:0] sA = {{WIDTH{opA[WIDTH-1]}}, opA};
  wire signed [2*WIDTH-1:0] sB = {{WIDTH{opB[WIDTH-1]}}, opB};
  wire signed [2*WIDTH-1:0] sProd = sA * sB;
  assign prodS = sProd;
  assign prodU = {{WIDTH{1'b0}}, opA} * {{WIDTH{1'b0}}, opB};
  // Zero divisor gives all ones and the dividend instead of an X
  assign quoS = divZero ? '1 : WIDTH'($signed(opA) / $signed(opB));
  assign remS = divZero ? opA : WIDTH'($signed(opA) % $signed(opB));
  assign quoU = divZero ? '1 : opA / opB;
  assign remU = divZero ? opA : opA % opB;
endmodule
`default_nettype wire

// >>> rtl/rbx_exec_unit.sv
// Execution unit for branches, jumps, loads, field, product and CP0 ops
`default_nettype none
module rbx_exec_unit #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Issue
  input wire logic opValid,
  input wire rbx_pkg::rbx_op_t opCode,
  input wire logic [31:0] srcA,
  input wire logic [31:0] srcB,
  input wire logic [15:0] immValue,
  input wire logic [4:0] fieldPos,
  input wire logic [5:0] fieldSize,
  input wire logic [4:0] destIdx,
  input wire logic [4:0] targetIdx,
  input wire logic [31:0] pcValue,
  // Pipeline status
  input wire logic hazardPending,
  input wire logic debugEntry,
  // Data memory
  output logic memReq_q,
  output logic [31:0] memAddr_q,
  input wire logic [31:0] memRdata,
  input wire logic memAck,
  // Completion
  output logic busy_q,
  output logic done_q,
  // Register write-back
  output logic regWrEn_q,
  output logic [4:0] regWrIdx_q,
  output logic [31:0] regWrData_q,
  // Program flow
  output logic pcLoad_q,
  output logic [31:0] pcNext_q,
  output logic annulNext_q,
  // Architectural state
  output logic [31:0] prodTop_q,
  output logic [31:0] prodBottom_q,
  output logic linkFlag_q,
  output logic [31:0] linkAddr_q,
  output logic debugMode_q
);
  import rbx_pkg::*;

  if (WIDTH != 32) begin : gChk
    $error("rbx_exec_unit supports a 32-bit word only");
  end

  // ==========================================================
  // State
  rbx_state_t state_q;
  rbx_state_t state_d;
  rbx_op_t pendOp_q;
  rbx_op_t pendOp_d;
  logic [4:0] pendIdx_q;
  logic [4:0] pendIdx_d;
  logic [1:0] pendLane_q;
  logic [1:0] pendLane_d;
  logic [31:0] cp0Status_q;
  logic [31:0] cp0Status_d;
  logic [31:0] cp0ExcPc_q;
  logic [31:0] cp0ExcPc_d;
  logic [31:0] cp0ErrPc_q;
  logic [31:0] cp0ErrPc_d;
  logic [31:0] cp0DbgPc_q;
  logic [31:0] cp0DbgPc_d;
  logic memReq_d;
  logic [31:0] memAddr_d;
  logic done_d;
  logic regWrEn_d;
  logic [4:0] regWrIdx_d;
  logic [31:0] regWrData_d;
  logic pcLoad_d;
  logic [31:0] pcNext_d;
  logic annul_d;
  logic [63:0] pair_d;
  logic linkFlag_d;
  logic [31:0] linkAddr_d;
  logic debugMode_d;

  // ==========================================================
  // Arithmetic helpers
  logic [31:0] fieldPulled;
  logic [31:0] fieldPut;
  logic [63:0] prodS;
  logic [63:0] prodU;
  logic [31:0] quoS;
  logic [31:0] remS;
  logic [31:0] quoU;
  logic [31:0] remU;

  rbx_bit_field #(.WIDTH(32)) uField (
    .srcWord(srcA),
    .tgtWord(srcB),
    .pos(fieldPos),
    .size(fieldSize),
    .pulled(fieldPulled),
    .put(fieldPut)
  );

  rbx_product_unit #(.WIDTH(32)) uProd (
    .opA(srcA),
    .opB(srcB),
    .prodS(prodS),
    .prodU(prodU),
    .quoS(quoS),
    .remS(remS),
    .quoU(quoU),
    .remU(remU)
  );

  // ==========================================================
  // Decode
  wire accept = opValid && (state_q == ST_IDLE);
  wire loadDone = (state_q == ST_LOAD) && memAck;
  wire barrierDone = (state_q == ST_BARRIER) && !hazardPending;
  wire [31:0] immSigned = {{16{immValue[15]}}, immValue};
  wire [31:0] offsetScaled = immSigned << OFFSET_SHIFT;
  wire [31:0] branchTarget = pcValue + offsetScaled;
  wire [31:0] pcPlusLink = pcValue + LINK_STEP;
  wire [31:0] pcPlusCompact = pcValue + COMPACT_STEP;
  wire [31:0] upperImm = {16'h0000, immValue} << UPPER_SHIFT;
  wire [31:0] regAddr = srcA + immSigned;
  wire [31:0] pcRelAddr = pcValue + offsetScaled;
  wire [63:0] pairNow = {prodTop_q, prodBottom_q};
  wire srcNeg = srcA[SIGN_BIT];
  wire srcZero = (srcA == WORD_RESET);
  wire srcDiffer = (srcA != srcB);
  wire testZero = (srcB == WORD_RESET);
  wire errLevel = cp0Status_q[STATUS_ERL_BIT];
  wire leForm = (opCode == OP_BR_LEZ) || (opCode == OP_BR_LEZ_LK);
  wire neForm = (opCode == OP_BR_NE) || (opCode == OP_BR_NE_LK);
  wire linkBranch = (opCode == OP_BR_LTZ_LNK) || (opCode == OP_BR_LTZ_LNK_LK);
  wire likelyForm = opCode inside {OP_BR_LEZ_LK, OP_BR_LTZ_LK, OP_BR_LTZ_LNK_LK, OP_BR_NE_LK};
  wire takeBranch = leForm ? (srcNeg || srcZero) : (neForm ? srcDiffer : srcNeg);
  wire loadOp = opCode inside {OP_LOAD_LINKED, OP_LOAD_PCREL, OP_LOAD_WORD,
    OP_LOAD_BYTE, OP_LOAD_BYTE_U, OP_LOAD_HALF, OP_LOAD_HALF_U};
  wire [31:0] loadAddr = (opCode == OP_LOAD_PCREL) ? pcRelAddr : regAddr;

  // Register reads of coprocessor 0; unimplemented numbers read zero
  wire [31:0] cp0ReadData =
    (destIdx == CP0_STATUS) ? cp0Status_q :
    (destIdx == CP0_EXC_PC) ? cp0ExcPc_q :
    (destIdx == CP0_ERROR_PC) ? cp0ErrPc_q :
    (destIdx == CP0_DEBUG_PC) ? cp0DbgPc_q : WORD_RESET;

  // Lane pick assumes little-endian byte order within the word
  wire [7:0] laneByte = memRdata[{pendLane_q, 3'b000} +: 8];
  wire [15:0] laneHalf = memRdata[{pendLane_q[1], 4'h0} +: 16];
  wire [31:0] loadValue =
    (pendOp_q == OP_LOAD_BYTE) ? {{24{laneByte[7]}}, laneByte} :
    (pendOp_q == OP_LOAD_BYTE_U) ? {24'h00_0000, laneByte} :
    (pendOp_q == OP_LOAD_HALF) ? {{16{laneHalf[15]}}, laneHalf} :
    (pendOp_q == OP_LOAD_HALF_U) ? {16'h0000, laneHalf} : memRdata;

  // ==========================================================
  // Next-state logic
  always_comb begin
    state_d = state_q;
    pendOp_d = pendOp_q;
    pendIdx_d = pendIdx_q;
    pendLane_d = pendLane_q;
    cp0Status_d = cp0Status_q;
    cp0ExcPc_d = cp0ExcPc_q;
    cp0ErrPc_d = cp0ErrPc_q;
    cp0DbgPc_d = cp0DbgPc_q;
    memReq_d = memReq_q;
    memAddr_d = memAddr_q;
    done_d = 1'b0;
    regWrEn_d = 1'b0;
    regWrIdx_d = regWrIdx_q;
    regWrData_d = regWrData_q;
    pcLoad_d = 1'b0;
    pcNext_d = pcNext_q;
    annul_d = 1'b0;
    pair_d = pairNow;
    linkFlag_d = linkFlag_q;
    linkAddr_d = linkAddr_q;
    debugMode_d = debugMode_q;
    if (loadDone) begin
      state_d = ST_IDLE;
      memReq_d = 1'b0;
      done_d = 1'b1;
      regWrEn_d = 1'b1;
      regWrIdx_d = pendIdx_q;
      regWrData_d = loadValue;
    end
    if (barrierDone) begin
      state_d = ST_IDLE;
      done_d = 1'b1;
    end
    if (accept) begin
      done_d = 1'b1;
      case (opCode)
        OP_BR_LEZ, OP_BR_LEZ_LK, OP_BR_LTZ, OP_BR_LTZ_LK,
        OP_BR_LTZ_LNK, OP_BR_LTZ_LNK_LK, OP_BR_NE, OP_BR_NE_LK: begin
          pcLoad_d = takeBranch;
          pcNext_d = branchTarget;
          annul_d = likelyForm && !takeBranch;
          if (linkBranch) begin
            regWrEn_d = 1'b1;
            regWrIdx_d = LINK_REG;
            regWrData_d = pcPlusLink;
          end
        end
        OP_DEBUG_RET: begin
          pcLoad_d = 1'b1;
          pcNext_d = cp0DbgPc_q;
          debugMode_d = 1'b0;
        end
        OP_EXC_RET: begin
          pcLoad_d = 1'b1;
          linkFlag_d = 1'b0;
          if (errLevel) begin
            pcNext_d = cp0ErrPc_q;
            cp0Status_d[STATUS_ERL_BIT] = 1'b0;
          end else begin
            pcNext_d = cp0ExcPc_q;
            cp0Status_d[STATUS_EXL_BIT] = 1'b0;
          end
        end
        OP_QUOT_S: pair_d = {remS, quoS};
        OP_QUOT_U: pair_d = {remU, quoU};
        OP_BARRIER: begin
          state_d = ST_BARRIER;
          done_d = 1'b0;
        end
        OP_FIELD_PULL, OP_FIELD_PUT: begin
          regWrEn_d = 1'b1;
          regWrIdx_d = targetIdx;
          regWrData_d = (opCode == OP_FIELD_PULL) ? fieldPulled : fieldPut;
        end
        OP_JUMP_LINK, OP_JUMP_LINK_HB, OP_JUMP_HB: begin
          pcLoad_d = 1'b1;
          pcNext_d = srcA;
          regWrEn_d = (opCode != OP_JUMP_HB);
          regWrIdx_d = destIdx;
          regWrData_d = pcPlusLink;
          if (opCode != OP_JUMP_LINK) begin
            state_d = ST_BARRIER;
            done_d = 1'b0;
          end
        end
        OP_CJUMP, OP_CJUMP_LINK: begin
          pcLoad_d = 1'b1;
          pcNext_d = srcA;
          annul_d = 1'b1;
          regWrEn_d = (opCode == OP_CJUMP_LINK);
          regWrIdx_d = destIdx;
          regWrData_d = pcPlusCompact;
        end
        OP_LOAD_LINKED, OP_LOAD_PCREL, OP_LOAD_WORD, OP_LOAD_BYTE,
        OP_LOAD_BYTE_U, OP_LOAD_HALF, OP_LOAD_HALF_U: begin
          state_d = ST_LOAD;
          done_d = 1'b0;
          memReq_d = 1'b1;
          memAddr_d = loadAddr;
          pendOp_d = opCode;
          pendIdx_d = targetIdx;
          pendLane_d = loadAddr[1:0];
          if (opCode == OP_LOAD_LINKED) begin
            linkFlag_d = 1'b1;
            linkAddr_d = loadAddr;
          end
        end
        OP_UPPER_IMM: begin
          regWrEn_d = 1'b1;
          regWrIdx_d = targetIdx;
          regWrData_d = upperImm;
        end
        OP_ACC_S: pair_d = pairNow + prodS;
        OP_ACC_U: pair_d = pairNow + prodU;
        OP_DED_S: pair_d = pairNow - prodS;
        OP_DED_U: pair_d = pairNow - prodU;
        OP_CP0_READ: begin
          regWrEn_d = 1'b1;
          regWrIdx_d = targetIdx;
          regWrData_d = cp0ReadData;
        end
        OP_CP0_WRITE: begin
          case (destIdx)
            CP0_STATUS: cp0Status_d = srcB;
            CP0_EXC_PC: cp0ExcPc_d = srcB;
            CP0_ERROR_PC: cp0ErrPc_d = srcB;
            CP0_DEBUG_PC: cp0DbgPc_d = srcB;
            default: cp0Status_d = cp0Status_q;
          endcase
        end
        OP_MOVE_ZERO, OP_MOVE_NONZERO: begin
          regWrEn_d = (opCode == OP_MOVE_ZERO) ? testZero : !testZero;
          regWrIdx_d = destIdx;
          regWrData_d = srcA;
        end
        OP_PROD_REG: begin
          regWrEn_d = 1'b1;
          regWrIdx_d = destIdx;
          regWrData_d = prodS[31:0];
        end
        OP_PROD_S: pair_d = prodS;
        OP_PROD_U: pair_d = prodU;
        OP_READ_TOP, OP_READ_BOTTOM: begin
          regWrEn_d = 1'b1;
          regWrIdx_d = destIdx;
          regWrData_d = (opCode == OP_READ_TOP) ? prodTop_q : prodBottom_q;
        end
        default: done_d = 1'b1;
      endcase
    end
    // Entry into debug mode wins over a return in the same cycle
    if (debugEntry) begin
      debugMode_d = 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      pendOp_q <= OP_NONE;
      pendIdx_q <= 5'h00;
      pendLane_q <= 2'h0;
      cp0Status_q <= WORD_RESET;
      cp0ExcPc_q <= WORD_RESET;
      cp0ErrPc_q <= WORD_RESET;
      cp0DbgPc_q <= WORD_RESET;
    end else begin
      state_q <= state_d;
      pendOp_q <= pendOp_d;
      pendIdx_q <= pendIdx_d;
      pendLane_q <= pendLane_d;
      cp0Status_q <= cp0Status_d;
      cp0ExcPc_q <= cp0ExcPc_d;
      cp0ErrPc_q <= cp0ErrPc_d;
      cp0DbgPc_q <= cp0DbgPc_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      memReq_q <= 1'b0;
      memAddr_q <= WORD_RESET;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      regWrEn_q <= 1'b0;
      regWrIdx_q <= 5'h00;
      regWrData_q <= WORD_RESET;
    end else begin
      memReq_q <= memReq_d;
      memAddr_q <= memAddr_d;
      busy_q <= (state_d != ST_IDLE);
      done_q <= done_d;
      regWrEn_q <= regWrEn_d;
      regWrIdx_q <= regWrIdx_d;
      regWrData_q <= regWrData_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pcLoad_q <= 1'b0;
      pcNext_q <= WORD_RESET;
      annulNext_q <= 1'b0;
      {prodTop_q, prodBottom_q} <= PAIR_RESET;
      linkFlag_q <= 1'b0;
      linkAddr_q <= WORD_RESET;
      debugMode_q <= 1'b0;
    end else begin
      pcLoad_q <= pcLoad_d;
      pcNext_q <= pcNext_d;
      annulNext_q <= annul_d;
      {prodTop_q, prodBottom_q} <= pair_d;
      linkFlag_q <= linkFlag_d;
      linkAddr_q <= linkAddr_d;
      debugMode_q <= debugMode_d;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence seqBarrierHold;
    (state_q == ST_BARRIER) && hazardPending;
  endsequence
  sequence seqBarrierHeld;
    busy_q && !done_q;
  endsequence
  sequence seqLinkedIssue;
    accept && (opCode == OP_LOAD_LINKED);
  endsequence
  sequence seqLinkedHeld;
    linkFlag_q && memReq_q && busy_q;
  endsequence

  AST_LE_ZERO_TAKEN: assert property (
    accept && (opCode == OP_BR_LEZ) && (srcNeg || srcZero)
    |=> pcLoad_q && (pcNext_q == $past(branchTarget)))
    else $error("Branch on less or equal zero not taken");
  AST_LIKELY_ANNUL: assert property (
    accept && likelyForm |=> (annulNext_q == !pcLoad_q))
    else $error("Likely branch annul does not match outcome");
  AST_LT_ZERO: assert property (
    accept && (opCode == OP_BR_LTZ) |=> (pcLoad_q == $past(srcNeg)))
    else $error("Less than zero branch outcome wrong");
  AST_LINK_R31: assert property (
    accept && linkBranch |=> regWrEn_q && (regWrIdx_q == LINK_REG)
    && (regWrData_q == $past(pcValue) + LINK_STEP))
    else $error("Link branch did not save return address");
  AST_NE_TAKEN: assert property (
    accept && neForm |=> (pcLoad_q == $past(srcDiffer)))
    else $error("Not-equal branch outcome wrong");
  AST_DEBUG_RET: assert property (
    accept && (opCode == OP_DEBUG_RET) && !debugEntry
    |=> !debugMode_q && pcLoad_q && (pcNext_q == $past(cp0DbgPc_q)))
    else $error("Debug return failed");
  AST_BARRIER_HOLD: assert property (
    seqBarrierHold |=> seqBarrierHeld)
    else $error("Barrier released while hazards pending");
  AST_LINKED_LOAD: assert property (
    seqLinkedIssue |=> seqLinkedHeld ##0 (linkAddr_q == memAddr_q))
    else $error("Linked load did not reserve its address");
  AST_UPPER_IMM: assert property (
    accept && (opCode == OP_UPPER_IMM)
    |=> regWrEn_q && (regWrData_q[15:0] == 16'h0000)
    && (regWrData_q[31:16] == $past(immValue)))
    else $error("Upper immediate result wrong");
  AST_MOVE_ZERO: assert property (
    accept && (opCode == OP_MOVE_ZERO) |=> (regWrEn_q == $past(testZero)))
    else $error("Move-if-zero write enable wrong");
  AST_EXC_RET: assert property (
    accept && (opCode == OP_EXC_RET) |=> !linkFlag_q && pcLoad_q)
    else $error("Exception return left reservation set");
  AST_COMPACT_LINK: assert property (
    accept && (opCode == OP_CJUMP_LINK)
    |=> annulNext_q && (regWrData_q == $past(pcValue) + COMPACT_STEP))
    else $error("Compact jump-link wrong");
endmodule
`default_nettype wire

// >>> bench/rbx_mem_model.sv
// Data memory responder that answers loads after a chosen lag
`default_nettype none
module rbx_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Load request from the block, and the answer lag chosen by the bench
  input wire logic memReq_q,
  input wire logic [31:0] memAddr_q,
  input wire logic [3:0] lag,
  // Answer
  output logic memAck,
  output logic [31:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int waitCnt;
  initial begin
    memAck = 1'b0;
    memRdata = 32'h0;
    waitCnt = 0;
  end
  // ==========================================================
  // Word is the inverted address; an idle data bus toggles so stale data never matches
  always @(posedge clk) begin
    if (reset || !memReq_q || memAck) begin
      memAck <= 1'b0;
      waitCnt <= 0;
      memRdata <= ~memRdata;
    end else if (waitCnt >= lag) begin
      memAck <= 1'b1;
      memRdata <= ~memAddr_q;
    end else begin
      waitCnt <= waitCnt + 1;
      memRdata <= ~memRdata;
    end
  end
endmodule
`default_nettype wire

// >>> bench/test_risc_branch_load_muldiv_exec.sv
// Self-checking bench for the execution unit
`default_nettype none
module test_risc_branch_load_muldiv_exec;
  timeunit 1ns;
  timeprecision 1ns;
  import rbx_pkg::*;
  typedef struct {
    rbx_op_t op;
    logic [31:0] a, b;
    logic w;
    logic [31:0] d;
    logic p;
    logic [31:0] n;
    logic an;
    logic [63:0] hl;
  } rbx_row_t;
  localparam logic [31:0] Z = 32'h0;
  localparam logic [31:0] TG = 32'hFFFE_0110;
  localparam logic [31:0] LK = 32'h0000_0108;
  localparam logic [63:0] P = 64'h0000_0002_FFFF_FFFA;
  logic clk = 1'b0, reset, opValid, hazardPending, debugEntry, memReq_q, memAck, busy_q, done_q;
  logic regWrEn_q, pcLoad_q, annulNext_q, linkFlag_q, debugMode_q, sWr, sPl, sAn;
  rbx_op_t opCode;
  logic [31:0] srcA, srcB, pcValue, memAddr_q, memRdata, regWrData_q, pcNext_q, lastD;
  logic [31:0] prodTop_q, prodBottom_q, linkAddr_q;
  logic [15:0] immValue = 16'h8004;
  logic [4:0] fieldPos = 5'h04, destIdx, targetIdx = 5'h07, regWrIdx_q;
  logic [5:0] fieldSize = 6'h08;
  logic [3:0] lag;
  int fails = 0, n_checks = 0, cyc = 0, nCyc;
  rbx_row_t rows[30] = '{
    '{OP_BR_LEZ, Z, Z, 0, Z, 1, TG, 0, 0},
    '{OP_BR_LEZ_LK, 32'h1, Z, 0, Z, 0, Z, 1, 0},
    '{OP_BR_LTZ, 32'h8000_0000, Z, 0, Z, 1, TG, 0, 0},
    '{OP_BR_LTZ_LK, 32'h7FFF_FFFF, Z, 0, Z, 0, Z, 1, 0},
    '{OP_BR_LTZ_LNK, Z, Z, 1, LK, 0, Z, 0, 0},
    '{OP_BR_LTZ_LNK_LK, 32'hFFFF_FFFF, Z, 1, LK, 1, TG, 0, 0},
    '{OP_BR_NE, 32'h1, 32'h2, 0, Z, 1, TG, 0, 0},
    '{OP_BR_NE_LK, 32'h3, 32'h3, 0, Z, 0, Z, 1, 0},
    '{OP_FIELD_PULL, 32'h1234_5678, Z, 1, 32'h67, 0, Z, 0, 0},
    '{OP_FIELD_PUT, 32'hAB, 32'hFFFF_FFFF, 1, 32'hFFFF_FABF, 0, Z, 0, 0},
    '{OP_JUMP_LINK, 32'h2000, Z, 1, LK, 1, 32'h2000, 0, 0},
    '{OP_JUMP_LINK_HB, 32'h2004, Z, 1, LK, 1, 32'h2004, 0, 0},
    '{OP_JUMP_HB, 32'h2008, Z, 0, Z, 1, 32'h2008, 0, 0},
    '{OP_CJUMP, 32'h200C, Z, 0, Z, 1, 32'h200C, 1, 0},
    '{OP_CJUMP_LINK, 32'h2010, Z, 1, 32'h102, 1, 32'h2010, 1, 0},
    '{OP_UPPER_IMM, Z, Z, 1, 32'h8004_0000, 0, Z, 0, 0},
    '{OP_MOVE_ZERO, 32'h55, Z, 1, 32'h55, 0, Z, 0, 0},
    '{OP_MOVE_NONZERO, 32'h55, Z, 0, Z, 0, Z, 0, 0},
    '{OP_MOVE_NONZERO, 32'h66, 32'h1, 1, 32'h66, 0, Z, 0, 0},
    '{OP_PROD_S, 32'hFFFF_FFFE, 32'h3, 0, Z, 0, Z, 0, 64'hFFFF_FFFF_FFFF_FFFA},
    '{OP_PROD_U, 32'hFFFF_FFFE, 32'h3, 0, Z, 0, Z, 0, P},
    '{OP_ACC_S, 32'hFFFF_FFFE, 32'h3, 0, Z, 0, Z, 0, P - 64'h6},
    '{OP_ACC_U, 32'h2, 32'h3, 0, Z, 0, Z, 0, P},
    '{OP_DED_S, 32'hFFFF_FFFF, 32'h1, 0, Z, 0, Z, 0, P + 64'h1},
    '{OP_DED_U, 32'h1, 32'h1, 0, Z, 0, Z, 0, P},
    '{OP_PROD_REG, 32'hFFFF_FFFD, 32'h5, 1, 32'hFFFF_FFF1, 0, Z, 0, P},
    '{OP_QUOT_S, 32'hFFFF_FFF9, 32'h2, 0, Z, 0, Z, 0, 64'hFFFF_FFFF_FFFF_FFFD},
    '{OP_QUOT_U, 32'h7, 32'h2, 0, Z, 0, Z, 0, 64'h0000_0001_0000_0003},
    '{OP_READ_TOP, Z, Z, 1, 32'h1, 0, Z, 0, 64'h0000_0001_0000_0003},
    '{OP_READ_BOTTOM, Z, Z, 1, 32'h3, 0, Z, 0, 64'h0000_0001_0000_0003}
  };
  always #25 clk = ~clk;
  rbx_exec_unit #(.WIDTH(32)) i_rbx_exec_unit (.clk, .reset, .opValid, .opCode, .srcA, .srcB,
    .immValue, .fieldPos, .fieldSize, .destIdx, .targetIdx, .pcValue, .hazardPending,
    .debugEntry, .memReq_q, .memAddr_q, .memRdata, .memAck, .busy_q, .done_q, .regWrEn_q,
    .regWrIdx_q, .regWrData_q, .pcLoad_q, .pcNext_q, .annulNext_q, .prodTop_q, .prodBottom_q,
    .linkFlag_q, .linkAddr_q, .debugMode_q);
  rbx_mem_model i_rbx_mem_model (.clk, .reset, .memReq_q, .memAddr_q, .lag, .memAck, .memRdata);
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Pulses are collected until done, since barrier forms finish later than they write
  task automatic issue(input rbx_op_t op, input logic [31:0] a, input logic [31:0] b);
    opCode = op;
    srcA = a;
    srcB = b;
    opValid = 1'b1;
    {sWr, sPl, sAn} = 3'h0;
    lastD = 'x;
    // Valid stays up after a one-cycle op so the next call never drops and raises it at once
    for (nCyc = 1; nCyc < 40; nCyc++) begin
      @(negedge clk);
      if (regWrEn_q === 1'b1) lastD = regWrData_q;
      sWr |= (regWrEn_q === 1'b1);
      sPl |= (pcLoad_q === 1'b1);
      sAn |= (annulNext_q === 1'b1);
      if (done_q === 1'b1) break;
      opValid = 1'b0;
    end
    chk("done", 1'b1, done_q);
  endtask
  task automatic load(input rbx_op_t op, input logic [31:0] ad, input logic [31:0] ex);
    issue(op, ad - 32'hFFFF_8004, Z);
    chk("load", ex, lastD);
  endtask
  task automatic cp0(input logic [4:0] r, input logic [31:0] v);
    destIdx = r;
    issue(OP_CP0_WRITE, Z, v);
  endtask
  task automatic results();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      $display("ERROR timeout expected finish seen hang");
      results();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    {reset, opValid, hazardPending, debugEntry} = 4'h8;
    opCode = OP_NONE;
    {srcA, srcB, pcValue, destIdx, lag} = {Z, Z, 32'h100, 5'h05, 4'h0};
    repeat (8) @(negedge clk);
    reset = 1'b0;
    chk("idle", 0, {busy_q, done_q, memReq_q, regWrEn_q, pcLoad_q, linkFlag_q, debugMode_q});
    chk("pair", 0, {prodTop_q, prodBottom_q});
    foreach (rows[i]) begin
      issue(rows[i].op, rows[i].a, rows[i].b);
      chk("write", rows[i].w, sWr);
      if (rows[i].w) chk("wdata", rows[i].d, lastD);
      chk("pcload", rows[i].p, sPl);
      if (rows[i].p) chk("pcnext", rows[i].n, pcNext_q);
      chk("annul", rows[i].an, sAn);
      chk("pair", rows[i].hl, {prodTop_q, prodBottom_q});
    end
    issue(OP_BR_LTZ_LNK, Z, Z);
    chk("linkidx", 5'h1F, regWrIdx_q);
    load(OP_LOAD_WORD, 32'h1004, 32'hFFFF_EFFB);
    load(OP_LOAD_BYTE, 32'h1001, 32'hFFFF_FFEF);
    load(OP_LOAD_BYTE_U, 32'h1001, 32'hEF);
    load(OP_LOAD_HALF, 32'h1000, 32'hFFFF_EFFF);
    lag = 4'h3;
    load(OP_LOAD_HALF_U, 32'h1000, 32'hEFFF);
    load(OP_LOAD_PCREL, 32'h1000, 32'h0001_FEEF);
    load(OP_LOAD_LINKED, 32'h1000, 32'hFFFF_EFFF);
    chk("link", {1'b1, 32'h1000}, {linkFlag_q, linkAddr_q});
    hazardPending = 1'b1;
    fork
      issue(OP_BARRIER, Z, Z);
      begin
        repeat (5) @(negedge clk);
        hazardPending = 1'b0;
      end
    join
    chk("stall", 1'b1, nCyc > 5 && nCyc < 9);
    cp0(5'h18, 32'h3000);
    issue(OP_CP0_READ, Z, Z);
    chk("cp0", 32'h3000, lastD);
    {debugEntry, opValid} = 2'b10;
    @(negedge clk);
    debugEntry = 1'b0;
    chk("dbgentry", 1'b1, debugMode_q);
    issue(OP_DEBUG_RET, Z, Z);
    chk("dret", {1'b1, 32'h3000, 1'b0}, {sPl, pcNext_q, debugMode_q});
    cp0(5'h0E, 32'h4000);
    issue(OP_EXC_RET, Z, Z);
    chk("eret", {1'b1, 32'h4000, 1'b0}, {sPl, pcNext_q, linkFlag_q});
    cp0(5'h0C, 32'h4);
    cp0(5'h1E, 32'h5000);
    issue(OP_EXC_RET, Z, Z);
    chk("erl", 32'h5000, pcNext_q);
    destIdx = 5'h0C;
    issue(OP_CP0_READ, Z, Z);
    chk("status", Z, lastD);
    results();
  end
endmodule
`default_nettype wire
